// File: rtl/acds_clkdiv.sv
// Purpose: converter clock divider off the master clock
// Assumes: div_code taken from the control register
// Notes: tick marks the first master clock of each converter period, with conv_clk high
`include "acds_defs.svh"
`default_nettype none
module acds_clkdiv (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] div_code,
  output logic tick,
  output logic conv_clk
);
  import acds_pkg::*;
  logic [3:0] cnt;
  wire [3:0] last = acds_div_last(div_code);
  // a code change to a shorter ratio may leave cnt past last: wrap anyway
  wire wrap = cnt >= last;
  wire [3:0] next_cnt = wrap ? 4'h0 : cnt + 4'h1;
  wire next_clk = next_cnt <= {1'b0, last[3:1]};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      tick <= 1'b0;
      conv_clk <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= wrap;
      conv_clk <= next_clk;
    end
  end
endmodule : acds_clkdiv
`default_nettype wire

// File: rtl/acds_defs.svh
// Purpose: constants for the converter control and dma sequencer
// Assumes: included by bare name from rtl files
// Notes: offsets, bit positions, reset values, access op codes and timing counts only
`ifndef ACDS_DEFS_SVH
`define ACDS_DEFS_SVH
// =====================================================================
// control register
`define ACDS_CTRL_ADDR 8'hEF
`define ACDS_CTRL_RESET 8'h00
`define ACDS_BIT_POWER 7
`define ACDS_BIT_EXTREF 6
`define ACDS_BIT_DIV_HI 5
`define ACDS_BIT_DIV_LO 4
`define ACDS_BIT_ACQ_HI 3
`define ACDS_BIT_ACQ_LO 2
`define ACDS_BIT_TIMER 1
`define ACDS_BIT_PIN 0
// =====================================================================
// converter timing: conversion in converter clock ticks, divider and settle counts in master clocks, first write in dma cycles
`define ACDS_CONV_TICKS 5'h11
`define ACDS_DIV16_LAST 4'hF
`define ACDS_DIV2_LAST 4'h1
`define ACDS_DIV4_LAST 4'h3
`define ACDS_DIV8_LAST 4'h7
`define ACDS_FIRST_WRITE_CYCLE 16'h0002
`define ACDS_STEADY_CLKS 5'h14
// =====================================================================
// external access sequencing, in master clocks
`define ACDS_OP_WR_HI 2'h0
`define ACDS_OP_WR_LO 2'h1
`define ACDS_OP_RD_ID 2'h2
`define ACDS_PH_STROBE_FIRST 3'h1
`define ACDS_PH_STROBE_LAST 3'h4
`define ACDS_PH_END 3'h7
`endif

// File: rtl/acds_pkg.sv
// Purpose: types and shared decode functions
// Assumes: acds_defs.svh for numeric constants
// Notes: none
`include "acds_defs.svh"
`default_nettype none
package acds_pkg;
  typedef enum logic [2:0] {
    ACDS_IDLE = 3'b001,
    ACDS_WAIT = 3'b010,
    ACDS_CONV = 3'b100
  } acds_state_t;
  typedef logic [3:0] acds_chan_t;
  typedef logic [11:0] acds_result_t;

  function automatic logic [3:0] acds_div_last(input logic [1:0] code);
    unique case (code)
      2'h0: acds_div_last = `ACDS_DIV16_LAST;
      2'h1: acds_div_last = `ACDS_DIV2_LAST;
      2'h2: acds_div_last = `ACDS_DIV4_LAST;
      2'h3: acds_div_last = `ACDS_DIV8_LAST;
    endcase
  endfunction : acds_div_last

  function automatic logic [4:0] acds_acq_ticks(input logic [1:0] code);
    acds_acq_ticks = {3'h0, code} + 5'h01;
  endfunction : acds_acq_ticks
endpackage : acds_pkg
`default_nettype wire

// File: rtl/acds_top.sv
// Purpose: converter control register, trigger logic and dma sequencer
// Assumes: analog core returns adc_result at the end of each conversion
// Notes: dma control inputs come from core logic on the same clock
// Function
// - control bit 7 powers the converter up when set, down when cleared
// - control bit 6 selects external reference when set, internal when cleared
// - divide code 00,01,10,11 divides master clock by 16,2,4,8
// - one conversion takes seventeen converter clocks beyond acquisition
// - acquire code 00..11 gives one to four converter clocks
// - with timer trigger enabled, each timer overflow starts a conversion
// - with pin trigger enabled, a low pulse on the pin starts conversion
// - sequencer runs on converter clock; one dma cycle is one conversion
// - each cycle converts the channel fetched in the preceding cycle
// - each cycle writes previous result with its channel identifier
// - each cycle fetches the channel identifier for the next cycle
// - first valid result is written in the third dma cycle
// - processor accesses to external ports are suppressed during dma
// - processor keeps running and internal data memory stays available
// - control register reads zero after reset
// - sequencer raises a request when the requested block is filled
`include "acds_defs.svh"
`default_nettype none
module acds_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic timer_overflow,
  input wire logic convert_start_pin_n,
  input wire logic dma_enable,
  input wire logic [23:0] dma_base_addr,
  input wire logic [15:0] dma_block_len,
  input wire acds_pkg::acds_result_t adc_result,
  output logic adc_power_on,
  output logic adc_external_reference_select,
  output logic converter_clock,
  output logic adc_track,
  output logic adc_convert,
  output acds_pkg::acds_chan_t adc_channel,
  output acds_pkg::acds_result_t single_result,
  output logic single_done,
  output logic dma_busy,
  output logic dma_irq_request,
  input wire logic [23:0] cpu_xaddr,
  input wire logic cpu_xrd,
  input wire logic cpu_xwr,
  input wire logic cpu_xint,
  input wire logic [7:0] cpu_xwdata,
  output logic [7:0] cpu_xrdata,
  output logic [23:0] mem_addr,
  output logic mem_rd_n,
  output logic mem_wr_n,
  output logic [7:0] mem_wdata,
  output logic mem_wdata_oe_n,
  input wire logic [7:0] mem_rdata
);
  import acds_pkg::*;

  // =====================================================================
  // control register
  logic [7:0] ctrl;
  wire ctrl_sel = sfr_addr == `ACDS_CTRL_ADDR;
  wire ctrl_wr = sfr_wr && ctrl_sel;
  wire power = ctrl[`ACDS_BIT_POWER];
  wire [1:0] div_code = {ctrl[`ACDS_BIT_DIV_HI], ctrl[`ACDS_BIT_DIV_LO]};
  wire [4:0] acq_n = acds_acq_ticks({ctrl[`ACDS_BIT_ACQ_HI], ctrl[`ACDS_BIT_ACQ_LO]});
  wire [4:0] conv_total = acq_n + `ACDS_CONV_TICKS;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `ACDS_CTRL_RESET;
      sfr_rdata <= 8'h00;
      adc_power_on <= 1'b0;
      adc_external_reference_select <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        ctrl <= sfr_wdata;
      end
      sfr_rdata <= ctrl_sel ? ctrl : 8'h00;
      adc_power_on <= power;
      adc_external_reference_select <= ctrl[`ACDS_BIT_EXTREF];
    end
  end

  // =====================================================================
  // converter clock
  logic div_tick;
  acds_clkdiv u_div (
    .clk(clk),
    .rst_n(rst_n),
    .div_code(div_code),
    .tick(div_tick),
    .conv_clk(converter_clock)
  );

  // =====================================================================
  // triggers: the pin is asynchronous, so it is synchronised first
  logic pin_meta;
  logic pin_sync;
  logic pin_prev;
  logic [7:0] data_meta;
  logic [7:0] data_sync;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
      pin_prev <= 1'b1;
      data_meta <= 8'h00;
      data_sync <= 8'h00;
    end else begin
      pin_meta <= convert_start_pin_n;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
      data_meta <= mem_rdata;
      data_sync <= data_meta;
    end
  end
  wire pin_fall = pin_prev && !pin_sync;
  wire timer_evt = ctrl[`ACDS_BIT_TIMER] && timer_overflow;
  wire pin_evt = ctrl[`ACDS_BIT_PIN] && pin_fall;
  wire trig_evt = timer_evt || pin_evt;

  // =====================================================================
  // conversion state machine
  acds_state_t state;
  acds_state_t next_state;
  logic [4:0] tick_cnt;
  logic trig_pend;
  wire free_run = dma_busy && !ctrl[`ACDS_BIT_TIMER] && !ctrl[`ACDS_BIT_PIN];
  // single conversions are held off while dma is requested but finished
  wire go_ok = dma_busy || !dma_enable;
  wire go = go_ok && (trig_evt || trig_pend || free_run);
  wire in_conv = state == ACDS_CONV;
  wire conv_last = in_conv && div_tick && tick_cnt == conv_total - 5'h01;
  wire dma_start = power && dma_enable && !dma_busy && !dma_irq_request && !in_conv;
  wire dma_stop = dma_busy && (!dma_enable || !power);
  logic [15:0] wr_count;
  wire finish = dma_busy && conv_last && wr_count == dma_block_len;
  wire take = state == ACDS_WAIT && go && !dma_stop && power;
  wire next_pend = power && (trig_evt || trig_pend) && !take;
  wire [4:0] next_tick_cnt = !in_conv ? 5'h00 : div_tick ? tick_cnt + 5'h01 : tick_cnt;

  always_comb begin
    next_state = state;
    unique case (state)
      ACDS_IDLE: begin
        if (power && (dma_start || !dma_enable)) begin
          next_state = ACDS_WAIT;
        end
      end
      ACDS_WAIT: begin
        if (!power || dma_stop) begin
          next_state = ACDS_IDLE;
        end else if (go) begin
          next_state = ACDS_CONV;
        end
      end
      ACDS_CONV: begin
        if (!power || dma_stop || finish) begin
          next_state = ACDS_IDLE;
        end else if (conv_last) begin
          next_state = ACDS_WAIT;
        end
      end
      default: next_state = ACDS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ACDS_IDLE;
      tick_cnt <= 5'h00;
      trig_pend <= 1'b0;
      adc_track <= 1'b0;
      adc_convert <= 1'b0;
    end else begin
      state <= next_state;
      tick_cnt <= next_tick_cnt;
      trig_pend <= next_pend;
      adc_track <= in_conv && tick_cnt < acq_n;
      adc_convert <= in_conv && tick_cnt >= acq_n;
    end
  end

  // =====================================================================
  // dma pipeline
  acds_chan_t conv_chan;
  acds_chan_t prev_chan;
  acds_chan_t fetched_chan;
  acds_result_t prev_result;
  logic conv_valid;
  logic prev_valid;
  logic fetched_valid;
  logic [15:0] fetch_count;
  logic [15:0] cyc_idx;
  logic mem_run;
  logic [1:0] mem_op;
  logic [2:0] mem_ph;
  wire ph_end = mem_run && mem_ph == `ACDS_PH_END;
  wire op_is_rd = mem_op == `ACDS_OP_RD_ID;
  wire in_strobe = mem_run && mem_ph >= `ACDS_PH_STROBE_FIRST && mem_ph <= `ACDS_PH_STROBE_LAST;
  wire dma_wr_strobe = in_strobe && !op_is_rd && prev_valid;
  wire dma_rd_strobe = in_strobe && op_is_rd;
  wire dma_drive = mem_run && !op_is_rd && prev_valid;
  wire fetch_done = ph_end && op_is_rd;
  wire write_done = ph_end && mem_op == `ACDS_OP_WR_LO && prev_valid;
  wire cycle_begin = dma_busy && take;
  wire [23:0] wr_addr = dma_base_addr + {7'h00, wr_count, 1'b0} + {23'h000000, mem_op == `ACDS_OP_WR_LO};
  wire [23:0] rd_addr = dma_base_addr + {7'h00, fetch_count, 1'b0};
  wire [7:0] wr_byte = mem_op == `ACDS_OP_WR_HI ? {prev_chan, prev_result[11:8]} : prev_result[7:0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_run <= 1'b0;
      mem_op <= `ACDS_OP_WR_HI;
      mem_ph <= 3'h0;
    end else if (cycle_begin) begin
      mem_run <= 1'b1;
      mem_op <= `ACDS_OP_WR_HI;
      mem_ph <= 3'h0;
    end else if (mem_run) begin
      mem_ph <= mem_ph + 3'h1;
      if (ph_end) begin
        mem_op <= mem_op + 2'h1;
        mem_run <= !op_is_rd && dma_busy;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_chan <= 4'h0;
      conv_valid <= 1'b0;
      prev_chan <= 4'h0;
      prev_result <= 12'h000;
      prev_valid <= 1'b0;
      fetched_chan <= 4'h0;
      fetched_valid <= 1'b0;
      fetch_count <= 16'h0000;
      wr_count <= 16'h0000;
      cyc_idx <= 16'h0000;
    end else if (dma_start) begin
      conv_valid <= 1'b0;
      prev_valid <= 1'b0;
      fetched_valid <= 1'b0;
      fetch_count <= 16'h0000;
      wr_count <= 16'h0000;
      cyc_idx <= 16'h0000;
    end else if (dma_busy && conv_last) begin
      prev_result <= adc_result;
      prev_chan <= conv_chan;
      prev_valid <= conv_valid;
      conv_chan <= fetched_chan;
      conv_valid <= fetched_valid;
      fetched_valid <= 1'b0;
      cyc_idx <= cyc_idx + 16'h0001;
    end else begin
      if (fetch_done) begin
        fetched_chan <= data_sync[7:4];
        fetched_valid <= 1'b1;
        fetch_count <= fetch_count + 16'h0001;
      end
      if (write_done) begin
        wr_count <= wr_count + 16'h0001;
      end
    end
  end

  // =====================================================================
  // status and result outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_busy <= 1'b0;
      dma_irq_request <= 1'b0;
      single_result <= 12'h000;
      single_done <= 1'b0;
      adc_channel <= 4'h0;
    end else begin
      dma_busy <= dma_start || (dma_busy && !finish && !dma_stop);
      // completion wins over the clear in the same cycle
      dma_irq_request <= finish || (dma_irq_request && dma_enable);
      single_done <= conv_last && !dma_busy;
      if (conv_last && !dma_busy) begin
        single_result <= adc_result;
      end
      adc_channel <= conv_chan;
    end
  end

  // =====================================================================
  // shared external port: dma owns it whole, cpu strobes are dropped
  wire cpu_ext_wr = cpu_xwr && !cpu_xint;
  wire cpu_ext_rd = cpu_xrd && !cpu_xint;
  wire [23:0] next_mem_addr = dma_busy ? (op_is_rd ? rd_addr : wr_addr) : cpu_xaddr;
  wire next_wr_n = dma_busy ? !dma_wr_strobe : !cpu_ext_wr;
  wire next_rd_n = dma_busy ? !dma_rd_strobe : !cpu_ext_rd;
  wire [7:0] next_wdata = dma_busy ? wr_byte : cpu_xwdata;
  wire next_oe_n = dma_busy ? !dma_drive : !cpu_ext_wr;

  // no stall is returned to the core: it runs on through dma
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_addr <= 24'h000000;
      mem_rd_n <= 1'b1;
      mem_wr_n <= 1'b1;
      mem_wdata <= 8'h00;
      mem_wdata_oe_n <= 1'b1;
      cpu_xrdata <= 8'h00;
    end else begin
      mem_addr <= next_mem_addr;
      mem_rd_n <= next_rd_n;
      mem_wr_n <= next_wr_n;
      mem_wdata <= next_wdata;
      mem_wdata_oe_n <= next_oe_n;
      cpu_xrdata <= data_sync;
    end
  end

  // =====================================================================
  // checks
  logic [3:0] gap_cnt;
  logic [4:0] steady_cnt;
  logic [4:0] hi_cnt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_cnt <= 4'h0;
      steady_cnt <= 5'h00;
      hi_cnt <= 5'h00;
    end else begin
      gap_cnt <= div_tick ? 4'h0 : gap_cnt + 4'h1;
      steady_cnt <= ctrl_wr ? 5'h00 : (steady_cnt == `ACDS_STEADY_CLKS ? steady_cnt : steady_cnt + 5'h01);
      hi_cnt <= (!in_conv || conv_last) ? 5'h00 : (div_tick && tick_cnt >= acq_n) ? hi_cnt + 5'h01 : hi_cnt;
    end
  end

  sequence s_wr_pulse;
    !mem_wr_n [*4] ##1 mem_wr_n;
  endsequence
  sequence s_rd_pulse;
    !mem_rd_n [*4] ##1 mem_rd_n;
  endsequence

  chk_reg_reset: assert property (
    @(posedge clk) $rose(rst_n) |-> ctrl == `ACDS_CTRL_RESET && sfr_rdata == 8'h00)
    else $error("control register not zero after reset");
  chk_power_follow: assert property (
    @(posedge clk) disable iff (!rst_n) ctrl_wr |-> ##2 adc_power_on == $past(sfr_wdata[7], 2))
    else $error("power output does not follow control write");
  chk_ref_follow: assert property (
    @(posedge clk) disable iff (!rst_n) ##1 adc_external_reference_select == $past(ctrl[`ACDS_BIT_EXTREF]))
    else $error("reference select does not follow control bit");
  chk_div_period: assert property (
    @(posedge clk) disable iff (!rst_n)
    div_tick && steady_cnt == `ACDS_STEADY_CLKS |-> gap_cnt == acds_div_last(div_code))
    else $error("converter clock period wrong for divide code");
  chk_conv_length: assert property (
    @(posedge clk) disable iff (!rst_n) conv_last |-> hi_cnt == `ACDS_CONV_TICKS - 5'h01)
    else $error("conversion phase not seventeen converter clocks");
  chk_acq_first: assert property (
    @(posedge clk) disable iff (!rst_n) $rose(adc_convert) |-> $past(adc_track) && tick_cnt >= acq_n)
    else $error("conversion began before acquisition ended");
  chk_timer_start: assert property (
    @(posedge clk) disable iff (!rst_n) state == ACDS_WAIT && timer_evt && go_ok && power && !dma_stop
    |=> state == ACDS_CONV)
    else $error("timer overflow did not start a conversion");
  chk_pin_start: assert property (
    @(posedge clk) disable iff (!rst_n) state == ACDS_WAIT && pin_evt && go_ok && power && !dma_stop
    |=> state == ACDS_CONV)
    else $error("pin pulse did not start a conversion");
  chk_first_write: assert property (
    @(posedge clk) disable iff (!rst_n) $fell(mem_wr_n) && dma_busy |-> cyc_idx >= `ACDS_FIRST_WRITE_CYCLE)
    else $error("result written before third dma cycle");
  chk_cpu_gated: assert property (
    @(posedge clk) disable iff (!rst_n) dma_busy && !dma_wr_strobe && cpu_ext_wr |=> mem_wr_n)
    else $error("processor write reached port during dma");
  chk_strobe_width: assert property (
    @(posedge clk) disable iff (!rst_n) $fell(mem_wr_n) && dma_busy |-> s_wr_pulse)
    else $error("dma write strobe width wrong");
  chk_fetch_strobe: assert property (
    @(posedge clk) disable iff (!rst_n) $fell(mem_rd_n) && dma_busy |-> s_rd_pulse ##2 fetched_valid)
    else $error("dma fetch strobe or capture wrong");
  chk_irq_done: assert property (
    @(posedge clk) disable iff (!rst_n) $rose(dma_irq_request) |-> $past(wr_count) == $past(dma_block_len))
    else $error("completion request before block filled");
endmodule : acds_top
`default_nettype wire

// File: testbench/acds_xmem_model.sv
// Purpose: external data memory on the far side of the sequencer ports
// Assumes: active low strobes, write data valid while the write strobe is low
// Notes: a released data bus shows the inverse of its last driven value
`default_nettype none
module acds_xmem_model (
  input wire logic clk,
  input wire logic [23:0] mem_addr,
  input wire logic mem_rd_n,
  input wire logic mem_wr_n,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_wdata_oe_n,
  output logic [7:0] mem_rdata,
  output logic wr_seen,
  output logic [23:0] wr_addr,
  output logic [7:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:63];
  logic [7:0] last_rd = 8'h00;
  logic prev_wr_n = 1'b1;
  initial wr_seen = 1'b0;
  // never leave a stale byte on a released bus, the sampler would take it
  assign mem_rdata = !mem_rd_n ? mem[mem_addr[5:0]] : ~last_rd;
  // =====================================================================
  // one log entry per falling write strobe
  always @(posedge clk) begin
    wr_seen <= !mem_wr_n && prev_wr_n;
    wr_addr <= mem_addr;
    wr_data <= mem_wdata_oe_n ? 8'hXX : mem_wdata;
    prev_wr_n <= mem_wr_n;
    if (!mem_wr_n) mem[mem_addr[5:0]] <= mem_wdata;
    if (!mem_rd_n) last_rd <= mem[mem_addr[5:0]];
  end
endmodule : acds_xmem_model
`default_nettype wire

// File: testbench/tb_top.sv
// Purpose: self-checking bench for converter control and dma sequencer
// Assumes: divide by 16 for all real conversions, with three or four acquisition ticks
// Notes: expected writes and results queue up, a monitor pops and compares
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import acds_pkg::*;
  localparam int CYC = 320; // (3 + 17) ticks of 16 clocks
  localparam logic [23:0] BASE = 24'h000010;
  localparam logic [31:0] DIVS [4] = '{32'h10, 32'h2, 32'h4, 32'h8};
  logic clk = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, timer_overflow = 1'b0, convert_start_pin_n = 1'b1;
  logic dma_enable = 1'b0, cpu_xrd = 1'b0, cpu_xwr = 1'b0, cpu_xint = 1'b0;
  logic [7:0] sfr_addr = 8'hEF, sfr_wdata = 8'h00, cpu_xwdata = 8'h00;
  logic [23:0] dma_base_addr = 24'h000000, cpu_xaddr = 24'h000000;
  logic [15:0] dma_block_len = 16'h0000;
  acds_result_t adc_result = 12'h000;
  logic [7:0] sfr_rdata, cpu_xrdata, mem_wdata, mem_rdata, wr_data;
  logic adc_power_on, adc_external_reference_select, converter_clock, adc_track, adc_convert, single_done;
  logic dma_busy, dma_irq_request, mem_rd_n, mem_wr_n, mem_wdata_oe_n, wr_seen;
  acds_chan_t adc_channel;
  acds_result_t single_result;
  logic [23:0] mem_addr, wr_addr;
  int miscompares = 0, check_count = 0, cyc = 0, trk = 0, cnv = 0, done_cnt = 0, wr_n = 0;
  int t_wr [0:15];
  logic [31:0] exp_wr [$];
  logic [31:0] exp_single [$];

  acds_top DUT (.clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata, .timer_overflow,
    .convert_start_pin_n, .dma_enable, .dma_base_addr, .dma_block_len, .adc_result, .adc_power_on,
    .adc_external_reference_select, .converter_clock, .adc_track, .adc_convert, .adc_channel, .single_result,
    .single_done, .dma_busy, .dma_irq_request, .cpu_xaddr, .cpu_xrd, .cpu_xwr, .cpu_xint,
    .cpu_xwdata, .cpu_xrdata, .mem_addr, .mem_rd_n, .mem_wr_n, .mem_wdata, .mem_wdata_oe_n, .mem_rdata);
  acds_xmem_model xm (.clk, .mem_addr, .mem_rd_n, .mem_wr_n, .mem_wdata, .mem_wdata_oe_n,
    .mem_rdata, .wr_seen, .wr_addr, .wr_data);

  always #12.5 clk = ~clk;

  // =====================================================================
  // tasks
  task automatic conclude;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask : chk

  task automatic step;
    @(posedge clk);
    #2;
  endtask : step

  task automatic sfr_write(input logic [7:0] d);
    step;
    sfr_wr = 1'b1;
    sfr_wdata = d;
    step;
    sfr_wr = 1'b0;
  endtask : sfr_write

  task automatic cc_rise;
    logic p;
    p = converter_clock;
    step;
    while (!(converter_clock && !p)) begin
      p = converter_clock;
      step;
    end
  endtask : cc_rise

  function automatic logic [3:0] chan(input int k);
    chan = 4'((k * 5 + 3) % 8);
  endfunction : chan

  // =====================================================================
  // monitor: pops the oldest note whenever a result appears
  always @(posedge clk) begin
    cyc++;
    if (adc_track) trk++;
    if (adc_convert) cnv++;
    if (cyc == 20000) begin
      miscompares++;
      conclude;
    end
    if (wr_seen) begin
      chk("external write", exp_wr.size() > 0 ? exp_wr.pop_front() : 'x, {wr_addr, wr_data});
      t_wr[wr_n[3:0]] = cyc;
      wr_n++;
    end
    if (single_done) begin
      done_cnt++;
      chk("single result", exp_single.size() > 0 ? exp_single.pop_front() : 'x, {20'h0, single_result});
    end
  end

  // =====================================================================
  // main sequence
  initial begin
    int n;
    int t0;
    logic [7:0] d;
    logic [31:0] r;
    void'($urandom(32'h8248));
    for (int k = 0; k < 32; k++) begin
      xm.mem[2 * k] = {chan(k), 4'h0};
      xm.mem[2 * k + 1] = 8'h00;
    end
    repeat (16) @(posedge clk);
    #2 rst_n = 1'b1;
    step;
    chk("ctrl reset", 32'h0, sfr_rdata);
    d = 8'($urandom) & 8'hFC;
    sfr_write(d);
    step;
    chk("ctrl readback", d, sfr_rdata);
    chk("power on", d[7], adc_power_on);
    chk("external_reference_select", d[6], adc_external_reference_select);
    sfr_addr = 8'hEE;
    step;
    chk("unmapped", 32'h0, sfr_rdata);
    sfr_addr = 8'hEF;
    // fast dividers are only measured, no conversion runs on them
    for (int c = 0; c < 4; c++) begin
      sfr_write({2'b10, 2'(c), 4'b1000});
      cc_rise;
      cc_rise;
      t0 = cyc;
      cc_rise;
      chk("divider", DIVS[c], cyc - t0);
    end
    for (int a = 2; a < 4; a++) begin
      sfr_write({4'b1000, 2'(a), 2'b10});
      r = $urandom;
      adc_result = r[11:0];
      exp_single.push_back({20'h0, r[11:0]});
      n = done_cnt;
      // trigger on a converter clock edge so every tick period is whole;
      // the first rise after a divide change may be a false one
      repeat (2) cc_rise;
      trk = 0;
      cnv = 0;
      timer_overflow = 1'b1;
      step;
      timer_overflow = 1'b0;
      for (int i = 0; i < 800 && done_cnt == n; i++) step;
      chk("track clocks", (a + 1) * 16, trk);
      chk("convert clocks", 17 * 16, cnv);
    end
    sfr_write(8'h88);
    n = done_cnt;
    repeat (2) step;
    timer_overflow = 1'b1;
    step;
    timer_overflow = 1'b0;
    repeat (400) step;
    chk("no trigger", n, done_cnt);
    sfr_write(8'h89);
    r = $urandom;
    adc_result = r[11:0];
    exp_single.push_back({20'h0, r[11:0]});
    repeat (2) step;
    convert_start_pin_n = 1'b0;
    repeat (6) step;
    convert_start_pin_n = 1'b1;
    for (int i = 0; i < 800 && done_cnt == n; i++) step;
    chk("pin conversion", n + 1, done_cnt);
    sfr_write(8'h00);
    step;
    chk("power off", 32'h0, adc_power_on);
    sfr_write(8'h88);
    r = $urandom;
    cpu_xaddr = 24'h000030;
    cpu_xwdata = r[7:0];
    exp_wr.push_back({24'h000030, r[7:0]});
    cpu_xwr = 1'b1;
    repeat (4) step;
    cpu_xwr = 1'b0;
    repeat (4) step;
    cpu_xrd = 1'b1;
    repeat (4) step;
    chk("cpu read", r[7:0], cpu_xrdata);
    cpu_xrd = 1'b0;
    repeat (4) step;
    cpu_xint = 1'b1;
    cpu_xwr = 1'b1;
    repeat (4) step;
    cpu_xwr = 1'b0;
    cpu_xint = 1'b0;
    repeat (4) step;
    r = $urandom;
    adc_result = r[11:0];
    dma_base_addr = BASE;
    dma_block_len = 16'h0003;
    for (int w = 0; w < 3; w++) begin
      exp_wr.push_back({BASE + 24'(2 * w), chan(w), r[11:8]});
      exp_wr.push_back({BASE + 24'(2 * w + 1), r[7:0]});
    end
    n = wr_n;
    dma_enable = 1'b1;
    t0 = cyc;
    step;
    chk("dma busy", 32'h1, dma_busy);
    repeat (100) step;
    cpu_xaddr = 24'h00003F;
    cpu_xwr = 1'b1;
    repeat (4) step;
    cpu_xwr = 1'b0;
    for (int i = 0; i < 3000 && dma_busy; i++) step;
    chk("block done", 32'h1, dma_irq_request);
    chk("writes left", 32'h0, exp_wr.size());
    chk("first write cycle", 32'h2, (t_wr[n] - t0) / CYC);
    chk("dma cycle length", CYC, t_wr[n + 2] - t_wr[n]);
    dma_enable = 1'b0;
    repeat (2) step;
    chk("request cleared", 32'h0, dma_irq_request);
    chk("last channel", chan(4), adc_channel);
    conclude;
  end
endmodule : tb_top
`default_nettype wire
